// file: rfc_pkg.sv
// Constants and types shared by the reference offset command register bank.
// Assumes a PMBus host front end delivers decoded commands on the link clock.
package rfc_pkg;
  localparam logic [7:0] CMD_REV = 8'hAE;
  localparam logic [7:0] CMD_SCRATCH = 8'hD0;
  localparam logic [7:0] CMD_TRIM = 8'hD4;
  localparam logic [7:0] CMD_MUP = 8'hD5;
  localparam logic [15:0] SCRATCH_WMASK = 16'h00FF;
  localparam logic [15:0] RST_SCRATCH = 16'h0000;
  localparam logic [15:0] RST_TRIM = 16'h0000;
  localparam logic [15:0] TRIM_MIN = 16'hFFC0;
  localparam logic [15:0] TRIM_MAX = 16'h003F;
  localparam logic [15:0] MUP_MIN = 16'h0000;
  localparam logic [15:0] MUP_MAX = 16'h001F;
  localparam logic [15:0] MUP_RESTORE0 = 16'h0009;
  localparam logic [15:0] MUP_RESTORE1 = 16'h000F;
  localparam logic [7:0] BLK_COUNT = 8'h02;
  localparam logic [4:0] VOUT_EXP = 5'h17;
  localparam logic [15:0] RATE_RESET = 16'h0000;
  localparam logic [15:0] REF_RESET = 16'h0000;
  localparam int OP_MARGIN_UP_BIT = 5;
  localparam int OP_MARGIN_DOWN_BIT = 4;
  typedef enum logic [1:0] {
    RS_SOFT_START = 2'b00,
    RS_STEADY = 2'b01,
    RS_TOFF_DELAY = 2'b10,
    RS_SOFT_STOP = 2'b11
  } rfc_ramp_t;
  typedef enum logic [1:0] {
    LS_IDLE = 2'b00,
    LS_WAIT = 2'b01,
    LS_RESP = 2'b10
  } rfc_lnk_t;
  typedef enum logic [1:0] {
    BY_FIRST = 2'b00,
    BY_SECOND = 2'b01,
    BY_THIRD = 2'b10
  } rfc_byte_t;
endpackage

// file: rfc_sync.sv
// Two flip-flop synchroniser for one level or toggle.
// Assumes the input is stable for at least two destination clock edges.
module rfc_sync (
  input wire logic i_clk,
  input wire logic i_d,
  output logic o_q
);
  logic meta;
  always_ff @(posedge i_clk) begin
    meta <= i_d;
    o_q <= meta;
  end
endmodule // rfc_sync

// file: rfc_regs.sv
// Reference offset command registers with a toggle handshake to the link side.
// Assumes link inputs are on i_lnk_clk and other inputs on i_clk.
// Operation
// - Revision command is read-only and answers with one 16-bit word.
// - Revision block read sends count 2, then low byte, then high byte.
// - Revision word is zero for first silicon, increments per revision.
// - Scratch word writes only low 8 bits; upper read zero; resets zero.
// - Store-all copies scratch and trim to nonvolatile storage.
// - Trim is a signed offset added to the reference target.
// - Reference is setpoint times scale plus trim plus selected margins.
// - Output format is linear, exponent minus nine, one count per step.
// - Loop slave ignores writes and NACKs access to trim and margin-up.
// - Loop slave access records invalid command fault and asserts alert.
// - Trim accepts minus 64 to plus 63 counts.
// - Out-of-range write clamps, asserts alert, sets summary and invalid data.
// - Reference target is limited by configured maximum and minimum.
// - Reference ramps at a rate chosen by the converter state.
// - Trim is sign-extended 16-bit two's complement, reset zero.
// - Margin high raises the target by the margin-up offset.
// - Margin-up accepts 0 to 31 in low five bits; high byte zero.
// - Margin-up restores to 0009h or 000Fh by the restore select bit.
// The revision value defaults to zero; each later silicon revision sets it one higher.
module rfc_regs #(
  parameter logic [15:0] REV_WORD = 16'h0000
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_lnk_clk,
  input wire logic i_cmd_valid,
  input wire logic [7:0] i_cmd_code,
  input wire logic i_cmd_write,
  input wire logic [15:0] i_cmd_wdata,
  input wire logic i_byte_req,
  input wire logic i_loop_slave_strap,
  input wire logic [7:0] i_operation,
  input wire logic [15:0] i_vout_command,
  input wire logic [3:0] i_scale_loop,
  input wire logic [15:0] i_margin_low,
  input wire logic [15:0] i_vout_max,
  input wire logic [15:0] i_vout_min,
  input wire logic [1:0] i_ramp_state,
  input wire logic [15:0] i_rate_ton,
  input wire logic [15:0] i_rate_trans,
  input wire logic [15:0] i_rate_toff,
  input wire logic i_store_all,
  input wire logic i_restore,
  input wire logic i_margin_up_restore_select,
  input wire logic [15:0] i_nv_scratch,
  input wire logic [15:0] i_nv_trim,
  input wire logic i_clear_faults,
  output logic o_cmd_ready,
  output logic o_rsp_valid,
  output logic o_rsp_nack,
  output logic [7:0] o_rsp_byte,
  output logic o_rsp_last,
  output logic [15:0] o_error_amp_reference,
  output logic [4:0] o_vout_exponent,
  output logic o_nv_wr,
  output logic [15:0] o_nv_scratch,
  output logic [15:0] o_nv_trim,
  output logic o_invalid_command_fault,
  output logic o_invalid_data,
  output logic o_cml_summary,
  output logic o_smbalert_n
);
  // Clamp a signed word to a signed range; the full word is checked.
  function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo,
                                          input logic [15:0] hi);
    if ($signed(v) < $signed(lo)) clamp16 = lo;
    else if ($signed(v) > $signed(hi)) clamp16 = hi;
    else clamp16 = v;
  endfunction

  // Link side: requests are held stable until the core answers by toggle.
  logic lnk_rst, req_tgl, ack_tgl, ack_s, ack_d, lnk_blk;
  logic [7:0] req_code;
  logic req_write;
  logic [15:0] req_wdata;
  rfc_pkg::rfc_lnk_t lnk_st;
  rfc_pkg::rfc_byte_t byte_ix;
  rfc_sync u_rst_lnk (.i_clk(i_lnk_clk), .i_d(i_rst), .o_q(lnk_rst));
  rfc_sync u_ack_lnk (.i_clk(i_lnk_clk), .i_d(ack_tgl), .o_q(ack_s));

  // Core side.
  logic req_s, req_d, req_ev, ls_s, loop_slave, strap_seen;
  logic rsp_nack, rsp_blk;
  logic [15:0] rsp_data, scratch, trim, mup, target;
  logic invalid_command_fault, ivd, cml, set_ivc, set_ivd;
  logic next_ivc, next_ivd, next_cml;
  logic prot, hit;
  logic [15:0] wclamp, ramp_cnt, rate;
  logic signed [21:0] sum;
  rfc_sync u_req_core (.i_clk(i_clk), .i_d(req_tgl), .o_q(req_s));
  rfc_sync u_strap (.i_clk(i_clk), .i_d(i_loop_slave_strap), .o_q(ls_s));

  always_ff @(posedge i_lnk_clk) begin
    if (lnk_rst) begin
      lnk_st <= rfc_pkg::LS_IDLE;
      req_tgl <= 1'b0;
      ack_d <= 1'b0;
      req_code <= 8'h00;
      req_write <= 1'b0;
      req_wdata <= 16'h0000;
      o_cmd_ready <= 1'b0;
      o_rsp_valid <= 1'b0;
      o_rsp_nack <= 1'b0;
      o_rsp_byte <= 8'h00;
      o_rsp_last <= 1'b0;
      byte_ix <= rfc_pkg::BY_FIRST;
      lnk_blk <= 1'b0;
    end else begin
      ack_d <= ack_s;
      case (lnk_st)
        rfc_pkg::LS_IDLE: begin
          o_cmd_ready <= 1'b1;
          if (i_cmd_valid && o_cmd_ready) begin
            req_code <= i_cmd_code;
            req_write <= i_cmd_write;
            req_wdata <= i_cmd_wdata;
            req_tgl <= ~req_tgl;
            o_cmd_ready <= 1'b0;
            lnk_st <= rfc_pkg::LS_WAIT;
          end
        end
        rfc_pkg::LS_WAIT: begin
          if (ack_s != ack_d) begin
            // Response words are stable in the core until the next request.
            o_rsp_valid <= 1'b1;
            o_rsp_nack <= rsp_nack;
            lnk_blk <= rsp_blk;
            byte_ix <= rfc_pkg::BY_FIRST;
            o_rsp_last <= rsp_nack || req_write;
            if (rsp_nack || req_write) o_rsp_byte <= 8'h00;
            else if (rsp_blk) o_rsp_byte <= rfc_pkg::BLK_COUNT;
            else o_rsp_byte <= rsp_data[7:0];
            lnk_st <= rfc_pkg::LS_RESP;
          end
        end
        rfc_pkg::LS_RESP: begin
          if (i_byte_req) begin
            if (o_rsp_last) begin
              o_rsp_valid <= 1'b0;
              o_rsp_last <= 1'b0;
              o_rsp_nack <= 1'b0;
              o_cmd_ready <= 1'b1;
              lnk_st <= rfc_pkg::LS_IDLE;
            end else if (byte_ix == rfc_pkg::BY_FIRST) begin
              byte_ix <= rfc_pkg::BY_SECOND;
              o_rsp_byte <= lnk_blk ? rsp_data[7:0] : rsp_data[15:8];
              o_rsp_last <= !lnk_blk;
            end else begin
              byte_ix <= rfc_pkg::BY_THIRD;
              o_rsp_byte <= rsp_data[15:8];
              o_rsp_last <= 1'b1;
            end
          end
        end
        default: lnk_st <= rfc_pkg::LS_IDLE;
      endcase
    end
  end

  // The strap is caught once after reset release, never under reset.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      strap_seen <= 1'b0;
      loop_slave <= 1'b0;
    end else if (!strap_seen) begin
      strap_seen <= 1'b1;
      loop_slave <= ls_s;
    end
  end

  always_comb begin
    req_ev = req_s ^ req_d;
    prot = (req_code == rfc_pkg::CMD_TRIM) || (req_code == rfc_pkg::CMD_MUP);
    hit = req_ev && req_write && !(prot && loop_slave);
    set_ivc = req_ev && prot && loop_slave;
    wclamp = (req_code == rfc_pkg::CMD_TRIM) ?
             clamp16(req_wdata, rfc_pkg::TRIM_MIN, rfc_pkg::TRIM_MAX) :
             clamp16(req_wdata, rfc_pkg::MUP_MIN, rfc_pkg::MUP_MAX);
    set_ivd = hit && prot && (wclamp != req_wdata);
    next_ivc = (invalid_command_fault && !i_clear_faults) || set_ivc;
    next_ivd = (ivd && !i_clear_faults) || set_ivd;
    next_cml = (cml && !i_clear_faults) || set_ivc || set_ivd;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      // Tracking the toggle under reset keeps a stale level from posing as a request.
      req_d <= req_s;
      ack_tgl <= 1'b0;
      rsp_nack <= 1'b0;
      rsp_blk <= 1'b0;
      rsp_data <= 16'h0000;
    end else begin
      req_d <= req_s;
      if (req_ev) begin
        ack_tgl <= ~ack_tgl;
        rsp_blk <= (req_code == rfc_pkg::CMD_REV);
        rsp_nack <= 1'b0;
        rsp_data <= 16'h0000;
        case (req_code)
          rfc_pkg::CMD_REV: begin
            rsp_data <= REV_WORD;
            rsp_nack <= req_write;
          end
          rfc_pkg::CMD_SCRATCH: rsp_data <= scratch;
          rfc_pkg::CMD_TRIM: begin
            rsp_data <= trim;
            rsp_nack <= loop_slave;
          end
          rfc_pkg::CMD_MUP: begin
            rsp_data <= mup;
            rsp_nack <= loop_slave;
          end
          default: rsp_nack <= 1'b1;
        endcase
      end
    end
  end

  // Restore loads first; a host write in the same cycle is then dropped.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      scratch <= rfc_pkg::RST_SCRATCH;
      trim <= rfc_pkg::RST_TRIM;
      mup <= rfc_pkg::MUP_RESTORE0;
    end else if (i_restore) begin
      scratch <= i_nv_scratch & rfc_pkg::SCRATCH_WMASK;
      trim <= clamp16(i_nv_trim, rfc_pkg::TRIM_MIN, rfc_pkg::TRIM_MAX);
      mup <= i_margin_up_restore_select ? rfc_pkg::MUP_RESTORE1 : rfc_pkg::MUP_RESTORE0;
    end else if (hit) begin
      case (req_code)
        rfc_pkg::CMD_SCRATCH: scratch <= req_wdata & rfc_pkg::SCRATCH_WMASK;
        rfc_pkg::CMD_TRIM: trim <= wclamp;
        rfc_pkg::CMD_MUP: mup <= wclamp;
        default: scratch <= scratch;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_nv_wr <= 1'b0;
      o_nv_scratch <= rfc_pkg::RST_SCRATCH;
      o_nv_trim <= rfc_pkg::RST_TRIM;
    end else begin
      o_nv_wr <= i_store_all;
      if (i_store_all) begin
        o_nv_scratch <= scratch;
        o_nv_trim <= trim;
      end
    end
  end

  // A fault raised in the cycle of a clear survives the clear.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      invalid_command_fault <= 1'b0;
      ivd <= 1'b0;
      cml <= 1'b0;
      o_smbalert_n <= 1'b1;
    end else begin
      invalid_command_fault <= next_ivc;
      ivd <= next_ivd;
      cml <= next_cml;
      o_smbalert_n <= !(next_ivc || next_ivd);
    end
  end
  assign o_invalid_command_fault = invalid_command_fault;
  assign o_invalid_data = ivd;
  assign o_cml_summary = cml;

  always_comb begin
    sum = $signed({2'h0, 20'(i_vout_command * i_scale_loop)})
          + $signed({{6{trim[15]}}, trim});
    if (i_operation[rfc_pkg::OP_MARGIN_UP_BIT]) sum = sum + $signed({6'h00, mup});
    if (i_operation[rfc_pkg::OP_MARGIN_DOWN_BIT])
      sum = sum + $signed({{6{i_margin_low[15]}}, i_margin_low});
    if (sum > $signed({6'h00, i_vout_max})) target = i_vout_max;
    else if (sum < $signed({6'h00, i_vout_min})) target = i_vout_min;
    else target = sum[15:0];
    case (rfc_pkg::rfc_ramp_t'(i_ramp_state))
      rfc_pkg::RS_SOFT_START: rate = i_rate_ton;
      rfc_pkg::RS_STEADY: rate = i_rate_trans;
      rfc_pkg::RS_TOFF_DELAY: rate = i_rate_trans;
      rfc_pkg::RS_SOFT_STOP: rate = i_rate_toff;
      default: rate = i_rate_trans;
    endcase
  end

  // One count per step keeps the ramp monotonic; each count takes the rate plus one cycles.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ramp_cnt <= rfc_pkg::RATE_RESET;
      o_error_amp_reference <= rfc_pkg::REF_RESET;
      o_vout_exponent <= rfc_pkg::VOUT_EXP;
    end else begin
      o_vout_exponent <= rfc_pkg::VOUT_EXP;
      if (ramp_cnt >= rate) begin
        ramp_cnt <= rfc_pkg::RATE_RESET;
        if (o_error_amp_reference < target)
          o_error_amp_reference <= o_error_amp_reference + 16'h0001;
        else if (o_error_amp_reference > target)
          o_error_amp_reference <= o_error_amp_reference - 16'h0001;
      end else begin
        ramp_cnt <= ramp_cnt + 16'h0001;
      end
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  rev_read_a: assert property (req_ev && req_code == rfc_pkg::CMD_REV |=>
    rsp_blk && rsp_data == REV_WORD) else $error("revision word wrong");
  scratch_hi_a: assert property (scratch[15:8] == 8'h00)
    else $error("scratch high byte not zero");
  trim_range_a: assert property ($signed(trim) >= $signed(rfc_pkg::TRIM_MIN) &&
    $signed(trim) <= $signed(rfc_pkg::TRIM_MAX)) else $error("trim out of range");
  mup_range_a: assert property (mup <= rfc_pkg::MUP_MAX)
    else $error("margin-up out of range");
  slave_nack_a: assert property (set_ivc |=> rsp_nack && invalid_command_fault && !o_smbalert_n)
    else $error("loop slave access not refused");
  clamp_flag_a: assert property (set_ivd |=> ivd && cml && !o_smbalert_n)
    else $error("clamp not flagged");
  ramp_step_a: assert property (o_error_amp_reference - $past(o_error_amp_reference)
    inside {16'h0000, 16'h0001, 16'hFFFF}) else $error("ramp step too large");
  store_copy_a: assert property (i_store_all |=> o_nv_wr && o_nv_trim == $past(trim))
    else $error("store did not copy trim");
  restore_mup_a: assert property (i_restore && i_margin_up_restore_select |=>
    mup == rfc_pkg::MUP_RESTORE1) else $error("margin-up restore wrong");
  blk_count_a: assert property (@(posedge i_lnk_clk) disable iff (lnk_rst)
    $rose(o_rsp_valid) && lnk_blk && !o_rsp_nack |-> o_rsp_byte == rfc_pkg::BLK_COUNT)
    else $error("block count wrong");

  rev_blk_c: cover property (req_ev && req_code == rfc_pkg::CMD_REV && !req_write);
  slave_c: cover property (set_ivc);
  clamp_c: cover property (set_ivd);
  ramp_c: cover property ($changed(o_error_amp_reference));
endmodule // rfc_regs

// file: rfc_host.sv
// Host model that issues command requests on the link side of the register bank.
// Assumes a free-running link clock and a device that answers in bounded time.
module rfc_host (
  input wire logic i_lnk_clk,
  input wire logic i_cmd_ready,
  input wire logic i_rsp_valid,
  input wire logic i_rsp_nack,
  input wire logic [7:0] i_rsp_byte,
  input wire logic i_rsp_last,
  output logic o_cmd_valid,
  output logic [7:0] o_cmd_code,
  output logic o_cmd_write,
  output logic [15:0] o_cmd_wdata,
  output logic o_byte_req
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd_code = 8'h00;
    o_cmd_write = 1'b0;
    o_cmd_wdata = 16'h0000;
    o_byte_req = 1'b0;
  end
  // Every access is a whole word transfer, never a byte read.
  task automatic xfer(input logic [7:0] c, input logic w, input logic [15:0] wd,
                      output logic [23:0] v, output int n, output logic nk, output logic ok);
    int t;
    logic done;
    v = 24'h000000;
    n = 0;
    nk = 1'b0;
    t = 0;
    done = 1'b0;
    @(negedge i_lnk_clk);
    o_cmd_valid = 1'b1;
    o_cmd_code = c;
    o_cmd_write = w;
    o_cmd_wdata = wd;
    // Ready is a register, so its value here is what the next rising edge samples.
    while (i_cmd_ready !== 1'b1 && t < 50) begin
      @(negedge i_lnk_clk);
      t++;
    end
    @(negedge i_lnk_clk);
    // Released lines show the inverse so a stale value can never pass for a good one.
    o_cmd_valid = 1'b0;
    o_cmd_code = ~c;
    o_cmd_write = ~w;
    o_cmd_wdata = ~wd;
    t = 0;
    while (!done && t < 200) begin
      @(negedge i_lnk_clk);
      t++;
      if (i_rsp_valid === 1'b1) begin
        v = v | (24'(i_rsp_byte) << (8 * n));
        nk = nk | i_rsp_nack;
        n++;
        done = (i_rsp_last === 1'b1) || (n == 3);
        o_byte_req = 1'b1;
        @(negedge i_lnk_clk);
        o_byte_req = 1'b0;
      end
    end
    ok = done;
  endtask
endmodule // rfc_host

// file: rfc_regs_tb.sv
// Self-checking bench for the reference offset command register bank.
// Assumes the host model drives the link side; core inputs change on falling edges.
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_mismatch++; \
  $display("unexpected at %0t got %h expected %h", $time, a, b); end end
module rfc_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] REV = 16'h0003; // Arbitrary revision value for the bench.
  localparam logic [7:0] CT = rfc_pkg::CMD_TRIM;
  localparam logic [7:0] CM = rfc_pkg::CMD_MUP;
  localparam logic [40:0] TAB [10] = '{{CT, 16'h003F, 16'h003F, 1'b0},
    {CT, 16'h0040, 16'h003F, 1'b1}, {CT, 16'hFFC0, 16'hFFC0, 1'b0},
    {CT, 16'hFFBF, 16'hFFC0, 1'b1}, {CT, 16'h00C0, 16'h003F, 1'b1},
    {CT, 16'h0005, 16'h0005, 1'b0}, {CM, 16'h001F, 16'h001F, 1'b0},
    {CM, 16'h0020, 16'h001F, 1'b1}, {CM, 16'hFFFF, 16'h0000, 1'b1},
    {CM, 16'h0005, 16'h0005, 1'b0}};
  logic i_clk = 1'b0;
  logic i_lnk_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_cmd_valid, i_cmd_write, i_byte_req, i_loop_slave_strap, i_store_all, i_restore;
  logic i_margin_up_restore_select, i_clear_faults;
  logic [7:0] i_cmd_code, i_operation;
  logic [15:0] i_cmd_wdata, i_vout_command, i_margin_low, i_vout_max, i_vout_min;
  logic [15:0] i_rate_ton, i_rate_trans, i_rate_toff, i_nv_scratch, i_nv_trim;
  logic [3:0] i_scale_loop;
  logic [1:0] i_ramp_state;
  logic o_cmd_ready, o_rsp_valid, o_rsp_nack, o_rsp_last, o_nv_wr;
  logic o_invalid_command_fault, o_invalid_data, o_cml_summary, o_smbalert_n;
  logic [7:0] o_rsp_byte;
  logic [15:0] o_error_amp_reference, o_nv_scratch, o_nv_trim;
  logic [4:0] o_vout_exponent;
  int n_mismatch = 0;
  int check_count = 0;
  always #2.5 i_clk = ~i_clk;
  // The link clock starts off phase so its edges drift against the core clock.
  initial begin
    #7;
    forever #24 i_lnk_clk = ~i_lnk_clk;
  end
  rfc_regs #(.REV_WORD(REV)) rfc_regs_i (.i_clk, .i_rst, .i_lnk_clk, .i_cmd_valid,
    .i_cmd_code, .i_cmd_write, .i_cmd_wdata, .i_byte_req, .i_loop_slave_strap,
    .i_operation, .i_vout_command, .i_scale_loop, .i_margin_low, .i_vout_max, .i_vout_min,
    .i_ramp_state, .i_rate_ton, .i_rate_trans, .i_rate_toff, .i_store_all, .i_restore,
    .i_margin_up_restore_select, .i_nv_scratch, .i_nv_trim, .i_clear_faults, .o_cmd_ready,
    .o_rsp_valid, .o_rsp_nack, .o_rsp_byte, .o_rsp_last, .o_error_amp_reference,
    .o_vout_exponent, .o_nv_wr, .o_nv_scratch, .o_nv_trim, .o_invalid_command_fault,
    .o_invalid_data, .o_cml_summary, .o_smbalert_n);
  rfc_host rfc_host_i (.i_lnk_clk(i_lnk_clk), .i_cmd_ready(o_cmd_ready),
    .i_rsp_valid(o_rsp_valid), .i_rsp_nack(o_rsp_nack), .i_rsp_byte(o_rsp_byte),
    .i_rsp_last(o_rsp_last), .o_cmd_valid(i_cmd_valid), .o_cmd_code(i_cmd_code),
    .o_cmd_write(i_cmd_write), .o_cmd_wdata(i_cmd_wdata), .o_byte_req(i_byte_req));
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // The link reset passes through link flops, so reset also spans three link edges.
  task automatic reset_dut();
    @(negedge i_clk);
    i_rst = 1'b1;
    repeat (16) @(negedge i_clk);
    repeat (3) @(posedge i_lnk_clk);
    @(negedge i_clk);
    i_rst = 1'b0;
  endtask
  task automatic pulse(ref logic s);
    @(negedge i_clk);
    s = 1'b1;
    @(negedge i_clk);
    s = 1'b0;
  endtask
  task automatic acc(input logic [7:0] c, input logic w, input logic [15:0] wd,
                     input logic xn, input logic [23:0] xv, input int xc);
    logic [23:0] v;
    int n;
    logic nk, ok;
    rfc_host_i.xfer(c, w, wd, v, n, nk, ok);
    `CHK(ok, 1'b1)
    `CHK(nk, xn)
    `CHK(n, xc)
    `CHK(v, xv)
  endtask
  task automatic settle(input logic [7:0] op, input logic [15:0] mx, input int cyc);
    @(negedge i_clk);
    i_operation = op;
    i_vout_max = mx;
    repeat (cyc) @(negedge i_clk);
  endtask
  initial begin
    repeat (20000) @(posedge i_clk);
    n_mismatch++;
    conclude();
  end
  initial begin
    {i_loop_slave_strap, i_store_all, i_restore, i_margin_up_restore_select} = 4'h0;
    i_clear_faults = 1'b0;
    i_operation = 8'h00;
    i_vout_command = 16'h0032;
    i_scale_loop = 4'h2;
    i_margin_low = 16'hFFFD;
    {i_vout_max, i_vout_min} = {16'hFFFF, 16'h0000};
    i_ramp_state = 2'h1;
    {i_rate_ton, i_rate_trans, i_rate_toff} = {16'h0000, 16'h0000, 16'h0000};
    {i_nv_scratch, i_nv_trim} = {16'h005A, 16'h0200};
    reset_dut();
    `CHK(o_vout_exponent, 5'h17)
    acc(rfc_pkg::CMD_REV, 1'b0, 16'h0000, 1'b0, {REV, 8'h02}, 3);
    acc(rfc_pkg::CMD_REV, 1'b1, 16'h1234, 1'b1, 24'h000000, 1);
    acc(rfc_pkg::CMD_SCRATCH, 1'b0, 16'h0000, 1'b0, 24'h000000, 2);
    acc(CT, 1'b0, 16'h0000, 1'b0, 24'h000000, 2);
    acc(CM, 1'b0, 16'h0000, 1'b0, 24'h000009, 2);
    acc(8'hD1, 1'b0, 16'h0000, 1'b1, 24'h000000, 1);
    `CHK(o_invalid_command_fault, 1'b0)
    acc(rfc_pkg::CMD_SCRATCH, 1'b1, 16'hA5C3, 1'b0, 24'h000000, 1);
    acc(rfc_pkg::CMD_SCRATCH, 1'b0, 16'h0000, 1'b0, 24'h0000C3, 2);
    for (int k = 0; k < 10; k++) begin
      pulse(i_clear_faults);
      acc(TAB[k][40:33], 1'b1, TAB[k][32:17], 1'b0, 24'h000000, 1);
      `CHK(o_invalid_data, TAB[k][0])
      `CHK(o_cml_summary, TAB[k][0])
      `CHK(o_smbalert_n, ~TAB[k][0])
      acc(TAB[k][40:33], 1'b0, 16'h0000, 1'b0, {8'h00, TAB[k][16:1]}, 2);
    end
    settle(8'h00, 16'hFFFF, 300);
    `CHK(o_error_amp_reference, 16'h0069)
    settle(8'h20, 16'hFFFF, 50);
    `CHK(o_error_amp_reference, 16'h006E)
    settle(8'h30, 16'hFFFF, 50);
    `CHK(o_error_amp_reference, 16'h006B)
    settle(8'h30, 16'h0068, 50);
    `CHK(o_error_amp_reference, 16'h0068)
    i_vout_min = 16'h0070;
    settle(8'h30, 16'hFFFF, 50);
    `CHK(o_error_amp_reference, 16'h0070)
    // Steady state must use the transition rate, four cycles a step, not the turn-on rate.
    i_rate_trans = 16'h0003;
    i_vout_min = 16'h0000;
    repeat (12) @(negedge i_clk);
    `CHK(o_error_amp_reference === 16'h006B, 1'b0)
    repeat (40) @(negedge i_clk);
    `CHK(o_error_amp_reference, 16'h006B)
    // Soft start and soft stop each pace the ramp on their own rate; turn-off delay uses the transition rate.
    {i_ramp_state, i_rate_ton, i_rate_trans} = {2'h0, 16'h0007, 16'h0000};
    settle(8'h20, 16'hFFFF, 12);
    `CHK(o_error_amp_reference === 16'h006E, 1'b0)
    settle(8'h20, 16'hFFFF, 40);
    `CHK(o_error_amp_reference, 16'h006E)
    {i_ramp_state, i_rate_ton, i_rate_trans} = {2'h2, 16'h0000, 16'h0007};
    settle(8'h30, 16'hFFFF, 12);
    `CHK(o_error_amp_reference === 16'h006B, 1'b0)
    settle(8'h30, 16'hFFFF, 40);
    `CHK(o_error_amp_reference, 16'h006B)
    {i_ramp_state, i_rate_trans, i_rate_toff} = {2'h3, 16'h0000, 16'h0007};
    settle(8'h20, 16'hFFFF, 12);
    `CHK(o_error_amp_reference === 16'h006E, 1'b0)
    settle(8'h20, 16'hFFFF, 40);
    `CHK(o_error_amp_reference, 16'h006E)
    {i_ramp_state, i_rate_toff} = {2'h1, 16'h0000};
    pulse(i_store_all);
    for (int t = 0; t < 4 && o_nv_wr !== 1'b1; t++) @(negedge i_clk);
    `CHK(o_nv_wr, 1'b1)
    `CHK(o_nv_scratch, 16'h00C3)
    `CHK(o_nv_trim, 16'h0005)
    @(negedge i_clk);
    `CHK(o_nv_wr, 1'b0)
    i_margin_up_restore_select = 1'b1;
    pulse(i_restore);
    acc(rfc_pkg::CMD_SCRATCH, 1'b0, 16'h0000, 1'b0, 24'h00005A, 2);
    acc(CT, 1'b0, 16'h0000, 1'b0, 24'h00003F, 2);
    acc(CM, 1'b0, 16'h0000, 1'b0, 24'h00000F, 2);
    i_margin_up_restore_select = 1'b0;
    pulse(i_restore);
    acc(CM, 1'b0, 16'h0000, 1'b0, 24'h000009, 2);
    i_loop_slave_strap = 1'b1;
    reset_dut();
    acc(CT, 1'b1, 16'h0010, 1'b1, 24'h000000, 1);
    `CHK(o_invalid_command_fault, 1'b1)
    `CHK(o_smbalert_n, 1'b0)
    acc(CM, 1'b0, 16'h0000, 1'b1, 24'h000000, 1);
    acc(rfc_pkg::CMD_SCRATCH, 1'b0, 16'h0000, 1'b0, 24'h000000, 2);
    settle(8'h30, 16'hFFFF, 300);
    `CHK(o_error_amp_reference, 16'h006A)
    conclude();
  end
endmodule // rfc_regs_tb
